// ===== core/mtg_defs.vh
`ifndef MTG_DEFS_VH
`define MTG_DEFS_VH
// Register offsets
`define MTG_CTRL_OFS 8'h00
`define MTG_UNIT_OFS 8'h04
`define MTG_TIME_OFS 8'h08
`define MTG_CONN_OFS 8'h0C
`define MTG_DIV_OFS 8'h10
`define MTG_STAT_OFS 8'h14
// Control fields
`define MTG_CTRL_MODE 0
`define MTG_CTRL_BCAST 1
`define MTG_CTRL_PROTO 3:2
`define MTG_PROTO_RTU 2'h0
`define MTG_PROTO_JBUS 2'h1
// Timing fields
`define MTG_TIME_TMO 3:0
`define MTG_TIME_IFD 7:4
`define MTG_TIME_SIE 11:8
// Reset values
`define MTG_CTRL_RST 4'h0
`define MTG_UNIT_RST 8'h01
`define MTG_TIME_RST 12'h004
`define MTG_CONN_RST 4'h4
`define MTG_DIV_RST 16'h2A6B
// Protocol constants
`define MTG_TCP_PORT 16'h01F6
`define MTG_UNIT_SELF 8'hFF
`define MTG_UNIT_BCAST 8'h00
`define MTG_EXC_FLAG 8'h80
`define MTG_EXC_NORSP 8'h0B
`define MTG_CRC_INIT 16'hFFFF
`define MTG_CRC_POLY 16'hA001
// Timing
`define MTG_CLK_NS 8
`define MTG_MS_NS 1000000
`define MTG_MS_CYC (`MTG_MS_NS / `MTG_CLK_NS)
`define MTG_SIL_HALF 7
`define MTG_IFD_STEP_MS 10
`endif

// ===== core/mtg_gateway.v
// Summary of operation
// [R1] Port 502 requests become RTU frames
// [R2] Unit 255 or own unit answered locally
// [R3] Other units forwarded to serial slaves
// [R4] Broadcasts always handled locally
// [R5] Broadcasts forwarded only when enabled
// [R6] Open connections limited to configured maximum
// [R7] Forwarding only in gateway mode
// [R8] Gateway needs RTU or Jbus protocol
// [R9] Reply timeout yields exception response
// [R10] Minimum delay before next request
// [R11] Silent interval is 3.5 chars plus extension
// [R12] After silence next char starts message
// [R13] Gateway timings apply only in gateway mode
// [R14] Slaves share baud, parity; unique units
// [R15] One outstanding request, reply to issuer
`timescale 1ns/1ps
`include "mtg_defs.vh"
module mtg_gateway #(
  parameter MS_CYC = `MTG_MS_CYC
) (
  // Clock and reset
  input wire core_clk,
  input wire resetn,
  // Register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // Connection admission
  input wire conn_open,
  input wire conn_close,
  output reg conn_grant,
  output reg conn_refuse,
  // TCP request stream, unit id first
  input wire req_valid,
  output wire req_ready,
  input wire [7:0] req_data,
  input wire req_last,
  input wire [2:0] req_conn,
  input wire [15:0] req_port,
  // Local request stream
  output reg loc_valid,
  input wire loc_ready,
  output reg [7:0] loc_data,
  output reg loc_last,
  output reg [2:0] loc_conn,
  // Response stream to masters
  output wire rsp_valid,
  input wire rsp_ready,
  output wire [7:0] rsp_data,
  output wire rsp_last,
  output wire [2:0] rsp_conn,
  // Serial byte stream
  output reg tx_valid,
  input wire tx_ready,
  output reg [7:0] tx_data,
  input wire rx_valid,
  input wire [7:0] rx_data
);
  localparam S_IDLE = 4'h0, S_LOC = 4'h1, S_FWD = 4'h2, S_BOTH = 4'h3, S_DROP = 4'h4;
  localparam S_CRCL = 4'h5, S_CRCH = 4'h6, S_WAIT = 4'h7, S_RSP = 4'h8, S_EXC = 4'h9;
  localparam S_GAP = 4'hA;

  // One step of the reflected CRC over a byte
  function [15:0] crc_step;
    input [15:0] c;
    input [7:0] d;
    integer i;
    reg [15:0] t;
    begin
      t = c ^ {8'h00, d};
      for (i = 0; i < 8; i = i + 1) begin
        t = t[0] ? ((t >> 1) ^ `MTG_CRC_POLY) : (t >> 1);
      end
      crc_step = t;
    end
  endfunction

  // Response timeout select to milliseconds
  function [13:0] tmo_ms;
    input [3:0] sel;
    begin
      if (sel < 4'h5) tmo_ms = {10'h000, sel + 4'h1} * 14'h0064;
      else if (sel < 4'hE) tmo_ms = {10'h000, sel - 4'h4} * 14'h03E8;
      else tmo_ms = 14'h2710;
    end
  endfunction

  reg [3:0] ctrl_reg;
  reg [7:0] unit_reg;
  reg [11:0] time_reg;
  reg [3:0] maxc_reg;
  reg [15:0] div_reg;
  reg [3:0] state_reg;
  reg [3:0] nconn_reg;
  reg [7:0] tmo_cnt_reg;
  reg [7:0] err_cnt_reg;
  reg [7:0] hd_unit_reg;
  reg [7:0] hd_fc_reg;
  reg [2:0] hd_conn_reg;
  reg hd_bcast_reg;
  reg hd_second_reg;
  reg hd_first_reg;
  reg [15:0] txcrc_reg;
  reg [16:0] ms_div_reg;
  reg [13:0] ms_cnt_reg;
  reg [15:0] half_div_reg;
  reg [5:0] sil_cnt_reg;
  reg frame_open_reg;
  reg frame_done_reg;
  reg [7:0] rx_len_reg;
  reg [15:0] rxcrc_reg;
  reg [7:0] rd_idx_reg;
  reg [1:0] exc_idx_reg;
  reg [7:0] rx_mem [0:255];

  // Gateway needs gateway mode and an RTU-type protocol
  wire gw_en = ctrl_reg[`MTG_CTRL_MODE] & // [R7]
    (ctrl_reg[`MTG_CTRL_PROTO] == `MTG_PROTO_RTU || ctrl_reg[`MTG_CTRL_PROTO] == `MTG_PROTO_JBUS); // [R8]
  wire hd_self = (req_data == `MTG_UNIT_SELF) | (req_data == unit_reg); // [R2]
  wire hd_bc = (req_data == `MTG_UNIT_BCAST);
  wire fwd_bc = hd_bc & ctrl_reg[`MTG_CTRL_BCAST] & gw_en; // [R5]

  // Two-entry response buffer; a stalled master holds the engine
  reg [11:0] fifo_mem [0:1];
  reg fifo_wp_reg, fifo_rp_reg;
  reg [1:0] fifo_cnt_reg;
  wire fifo_full = (fifo_cnt_reg == 2'h2);
  reg push;
  reg [11:0] push_word;
  wire pop = rsp_valid & rsp_ready;
  assign rsp_valid = (fifo_cnt_reg != 2'h0);
  assign {rsp_conn, rsp_last, rsp_data} = fifo_mem[fifo_rp_reg];

  // Request acceptance per state; IDLE only inspects the unit byte
  assign req_ready = (state_reg == S_LOC) ? ~loc_valid :
    (state_reg == S_FWD) ? ~tx_valid :
    (state_reg == S_BOTH) ? (~tx_valid & ~loc_valid) :
    (state_reg == S_DROP);
  wire req_take = req_valid & req_ready;

  // Millisecond and half-character enables
  wire ms_tick = (ms_div_reg == MS_CYC - 1);
  wire half_tick = (half_div_reg == div_reg);
  wire [5:0] sil_lim = 6'd`MTG_SIL_HALF + {1'b0, time_reg[`MTG_TIME_SIE], 1'b0}; // [R11]
  wire [13:0] gap_lim = {10'h000, time_reg[`MTG_TIME_IFD]} * 14'd`MTG_IFD_STEP_MS;
  wire [7:0] rsp_end = rx_len_reg - 8'h03;
  wire rx_good = (rx_len_reg > 8'h03) & (rxcrc_reg == 16'h0000) & (rx_mem[0] == hd_unit_reg);

  // Response buffer pushes from reply or exception
  always @* begin
    push = 1'b0;
    push_word = 12'h000;
    if (state_reg == S_RSP && !fifo_full) begin
      push = 1'b1;
      push_word = {hd_conn_reg, rd_idx_reg == rsp_end, rx_mem[rd_idx_reg]}; // [R15]
    end else if (state_reg == S_EXC && !fifo_full) begin
      push = 1'b1;
      case (exc_idx_reg)
        2'h0: push_word = {hd_conn_reg, 1'b0, hd_unit_reg};
        2'h1: push_word = {hd_conn_reg, 1'b0, hd_fc_reg | `MTG_EXC_FLAG};
        default: push_word = {hd_conn_reg, 1'b1, `MTG_EXC_NORSP};
      endcase
    end
  end

  // Buffer pointers
  always @(posedge core_clk) begin
    if (!resetn) begin
      fifo_wp_reg <= 1'b0;
      fifo_rp_reg <= 1'b0;
      fifo_cnt_reg <= 2'h0;
    end else begin
      if (push) begin
        fifo_mem[fifo_wp_reg] <= push_word;
        fifo_wp_reg <= ~fifo_wp_reg;
      end
      if (pop) fifo_rp_reg <= ~fifo_rp_reg;
      fifo_cnt_reg <= fifo_cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  // Register writes and read data, one cycle after the strobe
  always @(posedge core_clk) begin
    if (!resetn) begin
      ctrl_reg <= `MTG_CTRL_RST;
      unit_reg <= `MTG_UNIT_RST;
      time_reg <= `MTG_TIME_RST;
      maxc_reg <= `MTG_CONN_RST;
      div_reg <= `MTG_DIV_RST;
      reg_rdata <= 32'h00000000;
    end else begin
      if (reg_wr) begin
        case (reg_addr)
          `MTG_CTRL_OFS: ctrl_reg <= reg_wdata[3:0];
          `MTG_UNIT_OFS: unit_reg <= reg_wdata[7:0];
          `MTG_TIME_OFS: time_reg <= reg_wdata[11:0];
          `MTG_CONN_OFS: maxc_reg <= reg_wdata[3:0];
          `MTG_DIV_OFS: div_reg <= reg_wdata[15:0];
          default: ;
        endcase
      end
      reg_rdata <= 32'h00000000;
      if (reg_rd) begin
        case (reg_addr)
          `MTG_CTRL_OFS: reg_rdata <= {28'h0000000, ctrl_reg};
          `MTG_UNIT_OFS: reg_rdata <= {24'h000000, unit_reg};
          `MTG_TIME_OFS: reg_rdata <= {20'h00000, time_reg};
          `MTG_CONN_OFS: reg_rdata <= {28'h0000000, maxc_reg};
          `MTG_DIV_OFS: reg_rdata <= {16'h0000, div_reg};
          `MTG_STAT_OFS: reg_rdata <= {err_cnt_reg, tmo_cnt_reg, 7'h00, gw_en, nconn_reg, state_reg};
          default: reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Connection admission; a close in the same cycle frees a slot first
  always @(posedge core_clk) begin
    if (!resetn) begin
      nconn_reg <= 4'h0;
      conn_grant <= 1'b0;
      conn_refuse <= 1'b0;
    end else begin
      conn_grant <= 1'b0;
      conn_refuse <= 1'b0;
      if (conn_open && (nconn_reg - {3'h0, conn_close & (nconn_reg != 4'h0)}) < maxc_reg) begin // [R6]
        conn_grant <= 1'b1;
        if (!(conn_close && nconn_reg != 4'h0)) nconn_reg <= nconn_reg + 4'h1;
      end else begin
        conn_refuse <= conn_open;
        if (conn_close && nconn_reg != 4'h0) nconn_reg <= nconn_reg - 4'h1;
      end
    end
  end

  // Serial receive framing; idle while the gateway is off
  always @(posedge core_clk) begin
    if (!resetn || !gw_en) begin // [R13]
      half_div_reg <= 16'h0000;
      sil_cnt_reg <= 6'h00;
      frame_open_reg <= 1'b0;
      frame_done_reg <= 1'b0;
      rx_len_reg <= 8'h00;
      rxcrc_reg <= `MTG_CRC_INIT;
    end else begin
      frame_done_reg <= 1'b0;
      half_div_reg <= (half_tick || rx_valid) ? 16'h0000 : half_div_reg + 16'h0001;
      if (rx_valid) begin
        sil_cnt_reg <= 6'h00;
        frame_open_reg <= 1'b1;
        if (!frame_open_reg) begin // [R12]
          rx_mem[0] <= rx_data;
          rx_len_reg <= 8'h01;
          rxcrc_reg <= crc_step(`MTG_CRC_INIT, rx_data);
        end else begin
          rx_mem[rx_len_reg] <= rx_data;
          if (rx_len_reg != 8'hFF) rx_len_reg <= rx_len_reg + 8'h01;
          rxcrc_reg <= crc_step(rxcrc_reg, rx_data);
        end
      end else if (frame_open_reg && half_tick) begin
        sil_cnt_reg <= sil_cnt_reg + 6'h01;
        if (sil_cnt_reg + 6'h01 >= sil_lim) begin // [R11]
          frame_open_reg <= 1'b0;
          frame_done_reg <= 1'b1;
        end
      end
    end
  end

  // Main request sequencer, one transaction at a time
  always @(posedge core_clk) begin
    if (!resetn) begin
      state_reg <= S_IDLE;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      loc_valid <= 1'b0;
      loc_data <= 8'h00;
      loc_last <= 1'b0;
      loc_conn <= 3'h0;
      hd_unit_reg <= 8'h00;
      hd_fc_reg <= 8'h00;
      hd_conn_reg <= 3'h0;
      hd_bcast_reg <= 1'b0;
      hd_second_reg <= 1'b0;
      hd_first_reg <= 1'b0;
      txcrc_reg <= `MTG_CRC_INIT;
      ms_div_reg <= 17'h00000;
      ms_cnt_reg <= 14'h0000;
      rd_idx_reg <= 8'h00;
      exc_idx_reg <= 2'h0;
      tmo_cnt_reg <= 8'h00;
      err_cnt_reg <= 8'h00;
    end else begin
      if (tx_valid && tx_ready) tx_valid <= 1'b0;
      if (loc_valid && loc_ready) loc_valid <= 1'b0;
      ms_div_reg <= ms_tick ? 17'h00000 : ms_div_reg + 17'h00001;
      if (ms_tick) ms_cnt_reg <= ms_cnt_reg + 14'h0001;
      // Unit byte is taken first, so the function code is the take after it
      if (req_take) begin
        hd_first_reg <= 1'b0;
        hd_second_reg <= hd_first_reg;
        if (hd_second_reg) hd_fc_reg <= req_data;
        if (state_reg != S_LOC && state_reg != S_DROP) begin
          tx_valid <= 1'b1; // [R1]
          tx_data <= req_data;
          txcrc_reg <= crc_step(txcrc_reg, req_data);
        end
        if (state_reg == S_LOC || state_reg == S_BOTH) begin
          loc_valid <= 1'b1; // [R4]
          loc_data <= req_data;
          loc_last <= req_last;
          loc_conn <= hd_conn_reg;
        end
      end
      case (state_reg)
        S_IDLE: begin
          txcrc_reg <= `MTG_CRC_INIT;
          hd_first_reg <= 1'b1;
          hd_second_reg <= 1'b0;
          if (req_valid && !tx_valid) begin // [R15]
            hd_unit_reg <= req_data;
            hd_conn_reg <= req_conn;
            hd_bcast_reg <= hd_bc;
            if (req_port != `MTG_TCP_PORT) state_reg <= S_DROP; // [R1]
            else if (fwd_bc) state_reg <= S_BOTH; // [R5]
            else if (hd_self || hd_bc || !gw_en) state_reg <= S_LOC; // [R2] [R4] [R7]
            else state_reg <= S_FWD; // [R3]
          end
        end
        S_LOC, S_DROP: if (req_take && req_last) state_reg <= S_IDLE;
        S_FWD, S_BOTH: if (req_take && req_last) state_reg <= S_CRCL;
        S_CRCL: if (!tx_valid) begin
          tx_valid <= 1'b1;
          tx_data <= txcrc_reg[7:0];
          state_reg <= S_CRCH;
        end
        S_CRCH: if (!tx_valid) begin
          tx_valid <= 1'b1;
          tx_data <= txcrc_reg[15:8];
          ms_div_reg <= 17'h00000;
          ms_cnt_reg <= 14'h0000;
          state_reg <= hd_bcast_reg ? S_GAP : S_WAIT;
        end
        S_WAIT: begin
          if (frame_done_reg && rx_good) begin
            rd_idx_reg <= 8'h00;
            state_reg <= S_RSP;
          end else begin
            if (frame_done_reg) err_cnt_reg <= err_cnt_reg + 8'h01;
            if (ms_cnt_reg >= tmo_ms(time_reg[`MTG_TIME_TMO])) begin // [R9]
              tmo_cnt_reg <= tmo_cnt_reg + 8'h01;
              exc_idx_reg <= 2'h0;
              state_reg <= S_EXC;
            end
          end
        end
        S_RSP: if (!fifo_full) begin
          rd_idx_reg <= rd_idx_reg + 8'h01;
          if (rd_idx_reg == rsp_end) begin
            ms_div_reg <= 17'h00000;
            ms_cnt_reg <= 14'h0000;
            state_reg <= S_GAP;
          end
        end
        S_EXC: if (!fifo_full) begin
          exc_idx_reg <= exc_idx_reg + 2'h1;
          if (exc_idx_reg == 2'h2) begin
            ms_div_reg <= 17'h00000;
            ms_cnt_reg <= 14'h0000;
            state_reg <= S_GAP;
          end
        end
        // Gap counts from a cleared divider, so whole milliseconds pass
        S_GAP: if (ms_cnt_reg >= gap_lim && !tx_valid) state_reg <= S_IDLE; // [R10]
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule // mtg_gateway

// ===== tb/mtg_gateway_props.sv
`timescale 1ns/1ps
module mtg_gateway_props (
  // Clock, reset, register port
  input wire core_clk,
  input wire resetn,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  // Admission
  input wire conn_open,
  input wire conn_grant,
  input wire conn_refuse,
  // Streams
  input wire req_valid,
  input wire req_ready,
  input wire [7:0] req_data,
  input wire req_last,
  input wire rsp_valid,
  input wire rsp_ready,
  input wire [7:0] rsp_data,
  input wire [2:0] rsp_conn,
  input wire tx_valid,
  input wire tx_ready,
  input wire [7:0] tx_data
);
  reg [3:0] ctrl_reg;
  reg [7:0] own_reg;
  reg [7:0] unit_reg;
  reg first_reg;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  // Shadow config and the unit of the frame in flight
  always @(posedge core_clk) begin
    if (!resetn) begin
      ctrl_reg <= 4'h0;
      own_reg <= 8'h01;
      unit_reg <= 8'h00;
      first_reg <= 1'b1;
    end else begin
      if (reg_wr && reg_addr == 8'h00) ctrl_reg <= reg_wdata[3:0];
      if (reg_wr && reg_addr == 8'h04) own_reg <= reg_wdata[7:0];
      if (req_valid && req_ready) first_reg <= req_last;
      if (req_valid && req_ready && first_reg) unit_reg <= req_data;
    end
  end
  sequence s_tx_start;
    $rose(tx_valid);
  endsequence
  a_rd_slot: assert property (!reg_rd |=> reg_rdata == 32'h0) else $error("read data outside slot");
  a_conn_answer: assert property (conn_open |=> conn_grant != conn_refuse) else $error("no admission answer");
  a_conn_quiet: assert property (!conn_open |=> !conn_grant && !conn_refuse) else $error("spurious admission");
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)) else $error("tx dropped");
  a_rsp_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data) && $stable(rsp_conn))
    else $error("rsp dropped");
  a_gw_only: assert property (s_tx_start |-> ctrl_reg[0] && !ctrl_reg[3]) else $error("tx while off");
  a_self_local: assert property (s_tx_start |-> unit_reg != 8'hFF && unit_reg != own_reg)
    else $error("own unit forwarded");
  a_bcast_opt: assert property (s_tx_start |-> unit_reg != 8'h00 || ctrl_reg[1]) else $error("bcast forwarded");
endmodule // mtg_gateway_props
bind mtg_gateway mtg_gateway_props u_props (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .conn_open, .conn_grant, .conn_refuse, .req_valid, .req_ready, .req_data, .req_last, .rsp_valid,
  .rsp_ready, .rsp_data, .rsp_conn, .tx_valid, .tx_ready, .tx_data);

// ===== tb/mtg_slave_model.sv
`timescale 1ns/1ps
module mtg_slave_model (
  // Clock and reset
  input wire core_clk,
  input wire resetn,
  // Keep quiet to force a timeout
  input wire mute,
  // Serial bytes
  input wire tx_valid,
  output reg tx_ready,
  input wire [7:0] tx_data,
  output reg rx_valid,
  output reg [7:0] rx_data
);
  reg [7:0] frm [$];
  reg [7:0] ans [5];
  // Reflected CRC, low byte sent first
  function [15:0] crc_upd(input [15:0] c, input [7:0] d);
    integer k;
    begin
      c = c ^ {8'h00, d};
      for (k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
      crc_upd = c;
    end
  endfunction
  // Gather a request, answer once the line is quiet; idle rx shows the inverse
  initial begin : run
    integer idle, i;
    reg [15:0] c;
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    idle = 0;
    forever begin
      @(posedge core_clk);
      tx_ready <= resetn && ($urandom % 4 != 0);
      if (tx_valid && tx_ready) begin
        frm.push_back(tx_data);
        idle = 0;
      end else if (frm.size() != 0) begin
        idle = idle + 1;
        if (idle > 40) begin
          if (!mute && frm[0] != 8'h00) begin
            ans[0] = frm[0];
            ans[1] = frm[1];
            ans[2] = 8'h5A;
            c = 16'hFFFF;
            for (i = 0; i < 3; i++) c = crc_upd(c, ans[i]);
            ans[3] = c[7:0];
            ans[4] = c[15:8];
            for (i = 0; i < 5; i++) begin
              rx_valid <= 1'b1;
              rx_data <= ans[i];
              @(posedge core_clk);
              rx_valid <= 1'b0;
              rx_data <= ~ans[i];
              repeat (7) @(posedge core_clk);
            end
          end
          frm.delete();
          idle = 0;
        end
      end
    end
  end
endmodule // mtg_slave_model

// ===== tb/tb_mtg_gateway.sv
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; exp_v = (e); if ((g) !== exp_v) begin err_total++; \
  $display("Error %0t: got %h exp %h", $time, g, exp_v); end end
module tb_mtg_gateway;
  reg core_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, conn_open = 1'b0, conn_close = 1'b0;
  reg req_valid = 1'b0, req_last = 1'b0, loc_ready = 1'b0, rsp_ready = 1'b0, mute = 1'b0, rd_q = 1'b0, tx_q = 1'b0;
  reg [7:0] reg_addr = 8'h00, req_data = 8'h00;
  reg [31:0] reg_wdata = 32'h0, exp_v;
  reg [2:0] req_conn = 3'h0;
  reg [15:0] req_port = 16'h0000;
  wire [31:0] reg_rdata;
  wire [7:0] loc_data, rsp_data, tx_data, rx_data;
  wire [2:0] loc_conn, rsp_conn;
  wire conn_grant, conn_refuse, req_ready, loc_valid, loc_last, rsp_valid, rsp_last, tx_valid, tx_ready, rx_valid;
  reg [31:0] q_reg [$];
  reg [11:0] q_tx [$], q_rsp [$], q_loc [$];
  reg [1:0] q_con [$];
  // {ctrl, rsp, tx, loc, mute, unit, port}
  // Second entry follows a replied forward at once, so the frame gap is really exercised
  reg [31:0] tbl [12] = '{32'h1C22_01F6, 32'h1C23_01F6, 32'h1022_01F7, 32'h12FF_01F6, 32'h1211_01F6, 32'h1200_01F6,
    32'h3600_01F6, 32'h5C30_01F6, 32'h9230_01F6, 32'h0230_01F6, 32'h1D40_01F6, 32'h1C41_01F6};
  integer err_total = 0, compares = 0, gap = 100000, j;
  mtg_gateway #(.MS_CYC(20)) dut (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .conn_open, .conn_close, .conn_grant, .conn_refuse, .req_valid, .req_ready, .req_data, .req_last, .req_conn,
    .req_port, .loc_valid, .loc_ready, .loc_data, .loc_last, .loc_conn, .rsp_valid, .rsp_ready, .rsp_data,
    .rsp_last, .rsp_conn, .tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_data);
  mtg_slave_model u_slave (.core_clk, .resetn, .mute, .tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_data);
  // 8 ns period
  always #4 core_clk = ~core_clk;
  // Sinks stall at random; each result is matched to the oldest note
  always @(posedge core_clk) begin
    rsp_ready <= $urandom % 3 != 0;
    loc_ready <= $urandom % 3 != 0;
    rd_q <= reg_rd;
    tx_q <= tx_valid;
    gap <= rx_valid ? 0 : gap + 1;
    if (rd_q) `CHK(reg_rdata, q_reg.pop_front())
    if (conn_grant || conn_refuse) `CHK({conn_grant, conn_refuse}, q_con.pop_front())
    if (tx_valid && tx_ready) `CHK({4'h0, tx_data}, q_tx.pop_front())
    if (rsp_valid && rsp_ready) `CHK({rsp_conn, rsp_last, rsp_data}, q_rsp.pop_front())
    if (loc_valid && loc_ready) `CHK({loc_conn, loc_last, loc_data}, q_loc.pop_front())
    if (tx_valid && !tx_q) `CHK(gap > 200, 1'b1)
  end
  task close_out;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task rd(input [7:0] a, input [31:0] e);
    q_reg.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask
  task conn(input o, input c, input [1:0] e);
    q_con.push_back(e);
    conn_open <= o;
    conn_close <= c;
    @(posedge core_clk);
    conn_open <= 1'b0;
    conn_close <= 1'b0;
    @(posedge core_clk);
  endtask
  // Bounded wait until every tx, rsp and loc note has been met
  task drain;
    integer n;
    n = 0;
    while (q_tx.size() + q_rsp.size() + q_loc.size() != 0 && n < 9000) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 9000) begin
      err_total++;
      close_out;
    end
  endtask
  // k: rsp, tx, loc, mute; expected bytes noted before sending
  task frame(input [15:0] p, input [7:0] u, input [3:0] k);
    reg [7:0] b [3];
    reg [15:0] crc;
    reg [2:0] c;
    integer i, n;
    c = $urandom;
    b[0] = u;
    b[1] = 8'h01 + $urandom % 8'h7F;
    b[2] = $urandom;
    crc = 16'hFFFF;
    for (i = 0; i < 3; i++) begin
      crc = u_slave.crc_upd(crc, b[i]);
      if (k[1]) q_loc.push_back({c, i == 2, b[i]});
      if (k[2]) q_tx.push_back({4'h0, b[i]});
    end
    if (k[2]) q_tx.push_back({4'h0, crc[7:0]});
    if (k[2]) q_tx.push_back({4'h0, crc[15:8]});
    if (k[3]) q_rsp.push_back({c, 1'b0, u});
    if (k[3]) q_rsp.push_back({c, 1'b0, k[0] ? b[1] | 8'h80 : b[1]});
    if (k[3]) q_rsp.push_back({c, 1'b1, k[0] ? 8'h0B : 8'h5A});
    mute <= k[0];
    req_port <= p;
    req_conn <= c;
    for (i = 0; i < 3; i++) begin
      req_valid <= 1'b1;
      req_data <= b[i];
      req_last <= i == 2;
      n = 0;
      do begin
        @(posedge core_clk);
        n++;
      end while (!req_ready && n < 6000);
      if (n == 6000) begin
        err_total++;
        close_out;
      end
    end
    req_valid <= 1'b0;
    @(posedge core_clk);
  endtask
  // Reset values, configuration, admission, then every route
  initial begin
    j = $urandom(32'hBC4B);
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h1);
    rd(8'h08, 32'h4);
    rd(8'h0C, 32'h4);
    rd(8'h10, 32'h2A6B);
    wr(8'h1C, 32'hFFFFFFFF);
    rd(8'h1C, 32'h0);
    wr(8'h10, 32'h3);
    wr(8'h08, 32'h10);
    wr(8'h04, 32'h11);
    wr(8'h0C, 32'h2);
    rd(8'h08, 32'h10);
    $display("test registers done");
    conn(1'b1, 1'b0, 2'b10);
    conn(1'b1, 1'b0, 2'b10);
    conn(1'b1, 1'b0, 2'b01);
    conn(1'b1, 1'b1, 2'b10);
    $display("test connections done");
    for (j = 0; j < 12; j++) begin
      drain;
      wr(8'h00, {28'h0, tbl[j][31:28]});
      frame(tbl[j][15:0], tbl[j][23:16], tbl[j][27:24]);
    end
    drain;
    // Status after the gap: one timeout, two open connections, gateway on, idle
    repeat (300) @(posedge core_clk);
    rd(8'h14, 32'h0001_0120);
    @(posedge core_clk);
    $display("test routing done");
    close_out;
  end
endmodule // tb_mtg_gateway
